// ---- dv/los_bus_master.sv ----
// two-wire bus master model driving serial clock and data line
`timescale 1ns/100ps
`default_nettype none
module los_bus_master
(
  output var logic scl,
  output var logic sda_m,
  input  wire logic sda_line
);
  // clock stands high outside frames; released data floats to pull-up
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  // start or repeated start: data falls while clock high
  task automatic start_c();
    #16 sda_m = 1'b1;
    #16 scl = 1'b1;
    #16 sda_m = 1'b0;
    #16 scl = 1'b0;
  endtask

  // eight bits msb first, then release for the acknowledge slot
  task automatic byte_w(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      #16 sda_m = b[i];
      #16 scl = 1'b1;
      #32 scl = 1'b0;
    end
    #16 sda_m = 1'b1;
    #16 scl = 1'b1;
    ack = ~sda_line;
    #32 scl = 1'b0;
  endtask

  // eight bits read msb first with line released, then master ack or nack
  task automatic byte_r(input logic nack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      #16 sda_m = 1'b1;
      #16 scl = 1'b1;
      b[i] = sda_line;
      #32 scl = 1'b0;
    end
    #16 sda_m = nack;
    #16 scl = 1'b1;
    #32 scl = 1'b0;
  endtask

  task automatic stop_c();
    #16 sda_m = 1'b0;
    #16 scl = 1'b1;
    #16 sda_m = 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// self-checking bench for the logic-output and shutdown controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fails++; $display("Error %0t: got %h exp %h", $time, got, exp); end end
module tb_top
  import los_pkg::*;
;
  logic        ref_clk;
  logic        rst;
  logic        pin_level;
  logic        loop_back;
  logic        sel0;
  logic        sel1;
  logic [1:0]  exp_o;
  logic [7:0]  exp_w [4];
  int          fails;
  int          checks_done;
  wire logic   scl;
  wire logic   sda_m;
  wire logic   sda_out;
  wire logic   sda_oe;
  wire logic   out_one;
  wire logic   out_two;
  wire logic [3:0]  shut;
  wire logic [31:0] wiper;
  // open-drain wire and output one optionally fed back to the pin
  wire logic   sda_line = sda_m & ~(sda_oe & ~sda_out);
  wire logic   pin_n    = loop_back ? out_one : pin_level;

  los_bus_master u_los_bus_master
  (
    .scl      (scl),
    .sda_m    (sda_m),
    .sda_line (sda_line)
  );

  los_logic_output_shutdown_ctrl #(.NUM_CH(4)) u_los_logic_output_shutdown_ctrl
  (
    .rst              (rst),
    .ref_clk          (ref_clk),
    .link_scl         (scl),
    .sda_in           (sda_line),
    .sda_out          (sda_out),
    .sda_oe           (sda_oe),
    .addr_select_0    (sel0),
    .addr_select_1    (sel1),
    .shutdown_pin_n   (pin_n),
    .logic_output_one (out_one),
    .logic_output_two (out_two),
    .channel_shutdown (shut),
    .wiper_code       (wiper)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic complete_run();
    $display("fails %0d checks_done %0d", fails, checks_done);
    if (fails == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic settle();
    repeat (8) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input logic [3:0] exp_sd);
    `CHK({out_two, out_one}, exp_o)
    `CHK(shut, exp_sd)
    `CHK(wiper, {exp_w[3], exp_w[2], exp_w[1], exp_w[0]})
  endtask

  // f = {shutdown, output two, output one}; bits 7 and 0 set, ignored
  task automatic frame(input logic [1:0] ch, input logic [2:0] f,
                       input logic has_d, input logic [7:0] d,
                       input logic stp);
    logic ack;
    begin
      u_los_bus_master.start_c();
      u_los_bus_master.byte_w({ADDR_FIXED, 2'b10, 1'b0}, ack);
      `CHK(ack, 1'b1)
      u_los_bus_master.byte_w({1'b1, ch, 1'b0, f, 1'b1}, ack);
      `CHK(ack, 1'b1)
      exp_o = f[1:0];
      if (has_d)
      begin
        u_los_bus_master.byte_w(d, ack);
        `CHK(ack, 1'b1)
        exp_w[ch] = d;
      end
      if (stp)
        u_los_bus_master.stop_c();
      settle();
    end
  endtask

  task automatic clr();
    for (int k = 0; k < 4; k++)
      frame(2'(k), 3'b000, 1'b0, 8'h00, 1'b1);
  endtask

  task automatic t_outputs();
    logic ack;
    begin
      for (int k = 0; k < 4; k++)
      begin
        frame(2'(k), {1'b0, 2'(k)}, 1'b0, 8'h00, 1'b1);
        chk(4'h0);
      end
      u_los_bus_master.start_c();
      u_los_bus_master.byte_w({ADDR_FIXED, 2'b01, 1'b0}, ack);
      `CHK(ack, 1'b0)
      u_los_bus_master.byte_w(8'h00, ack);
      u_los_bus_master.stop_c();
      settle();
      chk(4'h0);
    end
  endtask

  task automatic t_sequences();
    frame(2'd1, 3'b001, 1'b1, 8'h5a, 1'b1);
    chk(4'h0);
    frame(2'd1, 3'b010, 1'b0, 8'h00, 1'b1);
    chk(4'h0);
    frame(2'd2, 3'b011, 1'b0, 8'h00, 1'b0);
    frame(2'd2, 3'b000, 1'b0, 8'h00, 1'b1);
    chk(4'h0);
  endtask

  task automatic t_shutdown();
    for (int k = 0; k < 4; k++)
    begin
      frame(2'(k), 3'b100, 1'b0, 8'h00, 1'b1);
      chk(4'(1 << k));
      frame(2'(k), 3'b000, 1'b0, 8'h00, 1'b1);
      chk(4'h0);
    end
    @(posedge ref_clk);
    pin_level <= 1'b0;
    settle();
    chk(4'hf);
    @(posedge ref_clk);
    pin_level <= 1'b1;
    settle();
    chk(4'h0);
  endtask

  task automatic t_quirks();
    frame(2'd0, 3'b000, 1'b1, 8'h11, 1'b1);
    frame(2'd1, 3'b100, 1'b0, 8'h00, 1'b1);
    chk(4'h3);
    clr();
    frame(2'd2, 3'b000, 1'b1, 8'h22, 1'b1);
    frame(2'd2, 3'b100, 1'b0, 8'h00, 1'b1);
    frame(2'd1, 3'b100, 1'b0, 8'h00, 1'b1);
    chk(4'h7);
    clr();
    frame(2'd0, 3'b000, 1'b1, 8'h33, 1'b1);
    frame(2'd0, 3'b000, 1'b0, 8'h00, 1'b1);
    frame(2'd1, 3'b100, 1'b0, 8'h00, 1'b1);
    chk(4'h2);
    clr();
    frame(2'd0, 3'b000, 1'b1, 8'h44, 1'b1);
    frame(2'd3, 3'b100, 1'b0, 8'h00, 1'b1);
    frame(2'd0, 3'b100, 1'b0, 8'h00, 1'b1);
    chk(4'h9);
    clr();
  endtask

  task automatic t_loopback();
    @(posedge ref_clk);
    loop_back <= 1'b1;
    settle();
    chk(4'hf);
    frame(2'd2, 3'b000, 1'b1, 8'h3c, 1'b1);
    chk(4'hf);
    frame(2'd2, 3'b001, 1'b0, 8'h00, 1'b1);
    chk(4'h0);
  endtask

  // readback of the selected channel, then midscale reset of it
  task automatic t_midscale();
    logic       ack;
    logic [7:0] rd;
    begin
      u_los_bus_master.start_c();
      u_los_bus_master.byte_w({ADDR_FIXED, 2'b10, 1'b1}, ack);
      `CHK(ack, 1'b1)
      u_los_bus_master.byte_r(1'b1, rd);
      u_los_bus_master.stop_c();
      `CHK(rd, exp_w[2])
      u_los_bus_master.start_c();
      u_los_bus_master.byte_w({ADDR_FIXED, 2'b10, 1'b0}, ack);
      `CHK(ack, 1'b1)
      u_los_bus_master.byte_w({1'b1, 2'd2, 1'b1, 3'b001, 1'b1}, ack);
      `CHK(ack, 1'b1)
      u_los_bus_master.stop_c();
      settle();
      exp_w[2] = WIPER_RST;
      chk(4'h0);
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    complete_run();
  end

  initial
  begin
    rst = 1'b1;
    pin_level = 1'b1;
    loop_back = 1'b0;
    sel0 = 1'b0;
    sel1 = 1'b1;
    fails = 0;
    checks_done = 0;
    exp_o = 2'b00;
    for (int k = 0; k < 4; k++)
      exp_w[k] = WIPER_RST;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    settle();
    chk(4'h0);
    t_outputs();
    t_sequences();
    t_shutdown();
    t_quirks();
    t_loopback();
    t_midscale();
    complete_run();
  end
endmodule
`default_nettype wire

// ---- src/los_i2c_link.sv ----
// two-wire bus slave running on the bus serial clock
`timescale 1ns/100ps
`default_nettype none
module los_i2c_link
  import los_pkg::*;
(
  input  wire logic rst,
  input  wire logic link_scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  los_link_if.link  lnk
);

  logic       start_tog_r;
  logic       start_seen_r;
  logic [3:0] bit_cnt_r;
  logic [1:0] byte_idx_r;
  logic       sel_r;
  logic       rd_r;
  logic       ack_due_r;
  logic [7:0] shift_r;
  logic       instr_tog_r;
  logic [7:0] instr_r;
  logic       data_tog_r;
  logic [7:0] data_r;
  logic [7:0] tx_r;
  logic       tx_en_r;
  logic       oe_r;

  wire        frame_start = start_tog_r ^ start_seen_r;
  wire  [7:0] full_byte   = {shift_r[6:0], sda_in};
  wire        last_bit    = (bit_cnt_r == LAST_BIT);
  wire        ack_slot    = (bit_cnt_r == ACK_SLOT);
  wire        addr_hit    = (full_byte[7:1] == {ADDR_FIXED, lnk.dev_addr_lo});
  wire        wr_sel      = sel_r & ~rd_r;
  wire        in_addr     = (byte_idx_r == BYTE_ADDR);
  wire        in_instr    = (byte_idx_r == BYTE_INSTR);

  // start condition: data falls while the clock is high
  always_ff @(negedge sda_in or posedge rst)
  begin
    if (rst)
      start_tog_r <= 1'b0;
    else if (link_scl)
      start_tog_r <= ~start_tog_r;
  end

  always_ff @(posedge link_scl or posedge rst)
  begin
    if (rst)
    begin
      start_seen_r <= 1'b0;
      bit_cnt_r    <= 4'h0;
      byte_idx_r   <= BYTE_ADDR;
      sel_r        <= 1'b0;
      rd_r         <= 1'b0;
      ack_due_r    <= 1'b0;
      shift_r      <= 8'h00;
      instr_tog_r  <= 1'b0;
      instr_r      <= 8'h00;
      data_tog_r   <= 1'b0;
      data_r       <= 8'h00;
      tx_r         <= 8'h00;
      tx_en_r      <= 1'b0;
    end
    else if (frame_start)
    begin
      // a new start restarts decoding, stop or not before it
      start_seen_r <= start_tog_r;
      shift_r      <= {7'h00, sda_in};
      bit_cnt_r    <= 4'h1;
      byte_idx_r   <= BYTE_ADDR;
      sel_r        <= 1'b0;
      ack_due_r    <= 1'b0;
      tx_en_r      <= 1'b0;
    end
    else if (ack_slot)
    begin
      bit_cnt_r <= 4'h0;
      ack_due_r <= 1'b0;
      if (byte_idx_r != BYTE_DATA)
        byte_idx_r <= byte_idx_r + 2'h1;
      // read data continues while the master acknowledges
      tx_en_r <= sel_r & rd_r & (in_addr | ~sda_in);
      tx_r    <= lnk.read_byte;
    end
    else
    begin
      shift_r   <= full_byte;
      bit_cnt_r <= bit_cnt_r + 4'h1;
      tx_r      <= {tx_r[6:0], 1'b0};
      if (last_bit)
      begin
        ack_due_r <= in_addr ? addr_hit : wr_sel;
        if (in_addr)
        begin
          sel_r <= addr_hit;
          rd_r  <= full_byte[0];
        end
        else if (wr_sel && in_instr)
        begin
          instr_r     <= full_byte;
          instr_tog_r <= ~instr_tog_r;
        end
        else if (wr_sel)
        begin
          data_r     <= full_byte;
          data_tog_r <= ~data_tog_r;
        end
      end
    end
  end

  // drive acknowledge and read bits while the clock is low
  always_ff @(negedge link_scl or posedge rst)
  begin
    if (rst)
      oe_r <= 1'b0;
    else
      oe_r <= (ack_slot & ack_due_r) |
              (tx_en_r & ~bit_cnt_r[3] & ~tx_r[7]);
  end

  assign sda_out        = 1'b0;
  assign sda_oe         = oe_r;
  assign lnk.instr_tog  = instr_tog_r;
  assign lnk.instr_byte = instr_r;
  assign lnk.data_tog   = data_tog_r;
  assign lnk.data_byte  = data_r;

endmodule
`default_nettype wire

// ---- src/los_link_if.sv ----
// carrier between the bus-side link logic and the reference-clock core
`timescale 1ns/100ps
`default_nettype none
interface los_link_if;
  logic       instr_tog;
  logic [7:0] instr_byte;
  logic       data_tog;
  logic [7:0] data_byte;
  logic [7:0] read_byte;
  logic [1:0] dev_addr_lo;

  modport link
  (
    output instr_tog,
    output instr_byte,
    output data_tog,
    output data_byte,
    input  read_byte,
    input  dev_addr_lo
  );

  modport core
  (
    input  instr_tog,
    input  instr_byte,
    input  data_tog,
    input  data_byte,
    output read_byte,
    output dev_addr_lo
  );
endinterface
`default_nettype wire

// ---- src/los_logic_output_shutdown_ctrl.sv ----
// logic outputs, channel shutdown and wiper store behind a two-wire slave
`timescale 1ns/100ps
`default_nettype none
module los_logic_output_shutdown_ctrl
  import los_pkg::*;
#(
  parameter int NUM_CH = NUM_CH_DEF
)
(
  input  wire logic              rst,
  input  wire logic              ref_clk,
  input  wire logic              link_scl,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  input  wire logic              addr_select_0,
  input  wire logic              addr_select_1,
  input  wire logic              shutdown_pin_n,
  output logic                   logic_output_one,
  output logic                   logic_output_two,
  output logic [NUM_CH-1:0]      channel_shutdown,
  output logic [NUM_CH*8-1:0]    wiper_code
);

  if (NUM_CH != 4)
  begin : g_bad_ch
    $error("channel count must be four for the subaddress decode");
  end

  los_link_if lnk ();

  los_i2c_link u_link
  (
    .rst      (rst),
    .link_scl (link_scl),
    .sda_in   (sda_in),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe),
    .lnk      (lnk.link)
  );

  // crossings from the bus clock and from pins
  logic [2:0]        inst_sync_r;
  logic [2:0]        data_sync_r;
  logic [1:0]        pin_sync_r;
  logic [1:0]        ad_meta_r;
  logic [1:0]        ad_sync_r;

  // core state
  logic              out_one_r;
  logic              out_two_r;
  logic [1:0]        sel_ch_r;
  logic [3:0]        shut_bit_r;
  logic [3:0]        shut_out_r;
  logic              arm_valid_r;
  logic [1:0]        arm_ch_r;
  logic              arm_shut_r;
  logic [7:0]        read_byte_r;
  logic [7:0]        wiper_r [NUM_CH];
  logic [7:0]        wiper_nxt [NUM_CH];

  function automatic logic [3:0] ch_bit(input logic [1:0] c);
    ch_bit = 4'h1 << c;
  endfunction

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      inst_sync_r <= 3'h0;
      data_sync_r <= 3'h0;
      pin_sync_r  <= 2'h3;
      ad_meta_r   <= 2'h0;
      ad_sync_r   <= 2'h0;
    end
    else
    begin
      inst_sync_r <= {inst_sync_r[1:0], lnk.instr_tog};
      data_sync_r <= {data_sync_r[1:0], lnk.data_tog};
      pin_sync_r  <= {pin_sync_r[0], shutdown_pin_n};
      ad_meta_r   <= {addr_select_1, addr_select_0};
      ad_sync_r   <= ad_meta_r;
    end
  end

  // event decode; the link holds its words for a full byte after a toggle
  wire       instr_evt = inst_sync_r[1] ^ inst_sync_r[2];
  wire       data_evt  = data_sync_r[1] ^ data_sync_r[2];
  wire       pin_shut  = ~pin_sync_r[1];

  // instruction byte fields; top and bottom bits are don't care
  wire [7:0] ib        = lnk.instr_byte;
  wire [1:0] ib_ch     = ib[IB_SUB_HI:IB_SUB_LO];
  wire       ib_midrst = ib[IB_MIDRST];
  wire       ib_shut   = ib[IB_SHUT];
  wire       ib_o2     = ib[IB_OUT_TWO];
  wire       ib_o1     = ib[IB_OUT_ONE];
  wire [1:0] partner   = ib_ch ^ 2'h1;

  // shutdown spreading after a data write to an armed channel
  wire       pair_hit   = arm_valid_r & (arm_ch_r == partner);
  wire       spread_hit = arm_valid_r & arm_shut_r &
                          (arm_ch_r[1] != ib_ch[1]);
  wire       same_arm   = arm_valid_r & (arm_ch_r == ib_ch);
  wire [3:0] shut_set   = ch_bit(ib_ch) |
                          (pair_hit ? ch_bit(arm_ch_r) : 4'h0) |
                          (spread_hit ? ch_bit(partner) : 4'h0);
  wire [3:0] shut_bit_nxt = !instr_evt ? shut_bit_r :
                            ib_shut ? (shut_bit_r | shut_set) :
                            (shut_bit_r & ~ch_bit(ib_ch));

  // an instruction with the shutdown bit low revives only its own channel;
  // the pin overrides every channel regardless of the stored bits
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      shut_bit_r <= SHUT_BIT_RST;
      shut_out_r <= SHUT_BIT_RST;
    end
    else
    begin
      shut_bit_r <= shut_bit_nxt;
      shut_out_r <= shut_bit_r | {4{pin_shut}};
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      out_one_r <= LOGIC_OUT_RST;
      out_two_r <= LOGIC_OUT_RST;
      sel_ch_r  <= 2'h0;
    end
    else if (instr_evt)
    begin
      out_one_r <= ib_o1;
      out_two_r <= ib_o2;
      sel_ch_r  <= ib_ch;
    end
  end

  // arming: a data write marks its channel until an instruction with the
  // shutdown bit low to the same channel or a spread consumes it
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      arm_valid_r <= 1'b0;
      arm_ch_r    <= 2'h0;
      arm_shut_r  <= 1'b0;
    end
    else if (data_evt)
    begin
      arm_valid_r <= 1'b1;
      arm_ch_r    <= sel_ch_r;
      arm_shut_r  <= 1'b0;
    end
    else if (instr_evt)
    begin
      if (ib_shut && (pair_hit || spread_hit))
        arm_valid_r <= 1'b0;
      else if (ib_shut && same_arm)
        arm_shut_r  <= 1'b1;
      else if (!ib_shut && same_arm)
        arm_valid_r <= 1'b0;
    end
  end

  // wiper store keeps taking data in shutdown; shutdown never alters it
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    wire sel_here = (sel_ch_r == 2'(i));
    wire rst_here = instr_evt & ib_midrst & (ib_ch == 2'(i));
    assign wiper_nxt[i] = rst_here ? WIPER_RST :
                          (data_evt & sel_here) ? lnk.data_byte :
                          wiper_r[i];
    always_ff @(posedge ref_clk or posedge rst)
    begin
      if (rst)
        wiper_r[i] <= WIPER_RST;
      else
        wiper_r[i] <= wiper_nxt[i];
    end
    assign wiper_code[i*8 +: 8] = wiper_r[i];
  end

  // readback word is quasi-static: it changes only after bus writes
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      read_byte_r <= WIPER_RST;
    else
      read_byte_r <= wiper_r[sel_ch_r];
  end

  assign lnk.read_byte   = read_byte_r;
  assign lnk.dev_addr_lo = ad_sync_r;
  assign logic_output_one = out_one_r;
  assign logic_output_two = out_two_r;
  assign channel_shutdown = shut_out_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_instr_arrives;
    $changed(lnk.instr_tog);
  endsequence

  sequence s_pin_held;
    !shutdown_pin_n [*3];
  endsequence

  chk_outputs_reset: assert property (
    $fell(rst) |-> !logic_output_one && !logic_output_two)
    else $error("logic outputs not low after reset");

  chk_outputs_follow: assert property (
    instr_evt |=> logic_output_one == $past(ib_o1) &&
                  logic_output_two == $past(ib_o2))
    else $error("logic outputs do not follow instruction byte");

  chk_outputs_hold: assert property (
    !instr_evt |=> $stable(logic_output_one) && $stable(logic_output_two))
    else $error("logic output changed without instruction");

  chk_instr_wiper: assert property (
    instr_evt && !ib_midrst |=> $stable(wiper_code))
    else $error("instruction-only write changed a wiper");

  chk_instr_cross: assert property (
    s_instr_arrives |-> ##[1:3] instr_evt)
    else $error("instruction byte lost in crossing");

  chk_pin_all_shut: assert property (
    s_pin_held |=> channel_shutdown == 4'hf)
    else $error("pin shutdown did not reach all channels");

  chk_bit_shut: assert property (
    instr_evt && ib_shut |-> ##2 channel_shutdown[$past(ib_ch, 2)])
    else $error("shutdown bit did not shut addressed channel");

  chk_pair_spread: assert property (
    instr_evt && ib_shut && pair_hit |->
      ##2 channel_shutdown[$past(arm_ch_r, 2)])
    else $error("pair shutdown did not spread");

  chk_far_spread: assert property (
    instr_evt && ib_shut && spread_hit |->
      ##2 channel_shutdown[$past(partner, 2)])
    else $error("cross-pair shutdown did not spread");

  chk_write_in_shut: assert property (
    data_evt |=> wiper_r[$past(sel_ch_r)] == $past(lnk.data_byte))
    else $error("data byte not stored");

  chk_release: assert property (
    $rose(pin_sync_r[1]) && shut_bit_r == 4'h0 |=> channel_shutdown == 4'h0)
    else $error("channels not released after pin goes high");

  chk_midscale_load: assert property (
    instr_evt && ib_midrst |=> wiper_r[$past(ib_ch)] == WIPER_RST)
    else $error("midscale reset did not load the addressed wiper");

  chk_wiper_quiet: assert property (
    !data_evt && !instr_evt |=> $stable(wiper_code))
    else $error("wiper changed without a bus write");

  chk_bit_clear: assert property (
    instr_evt && !ib_shut |=> !shut_bit_r[$past(ib_ch)])
    else $error("shutdown bit low did not release its channel");

  chk_bit_set: assert property (
    instr_evt && ib_shut |=> shut_bit_r[$past(ib_ch)])
    else $error("shutdown bit high did not set its channel");

  chk_bit_single: assert property (
    instr_evt && !pair_hit && !spread_hit |=>
      ((shut_bit_r ^ $past(shut_bit_r)) & ~ch_bit($past(ib_ch))) == 4'h0)
    else $error("shutdown bit touched another channel");

  chk_arm_on_data: assert property (
    data_evt |=> arm_valid_r && arm_ch_r == $past(sel_ch_r))
    else $error("data write did not arm its channel");

  chk_pin_override: assert property (
    pin_shut |=> channel_shutdown == 4'hf)
    else $error("synchronised pin did not shut every channel");

endmodule
`default_nettype wire

// ---- src/los_pkg.sv ----
// constants shared by the logic-output and shutdown controller
package los_pkg;

  // channel count served by the subaddress decode
  localparam int          NUM_CH_DEF    = 4;

  // fixed upper five bits of the seven-bit bus address
  localparam logic [4:0]  ADDR_FIXED    = 5'h0b;

  // instruction byte field positions
  localparam int          IB_SUB_HI     = 6;
  localparam int          IB_SUB_LO     = 5;
  localparam int          IB_MIDRST     = 4;
  localparam int          IB_SHUT       = 3;
  localparam int          IB_OUT_TWO    = 2;
  localparam int          IB_OUT_ONE    = 1;

  // reset values
  localparam logic [7:0]  WIPER_RST     = 8'h80;
  localparam logic        LOGIC_OUT_RST = 1'b0;
  localparam logic [3:0]  SHUT_BIT_RST  = 4'h0;

  // bit counter marks within one nine-clock byte slot
  localparam logic [3:0]  LAST_BIT      = 4'h7;
  localparam logic [3:0]  ACK_SLOT      = 4'h8;

  // byte index within a frame
  localparam logic [1:0]  BYTE_ADDR     = 2'h0;
  localparam logic [1:0]  BYTE_INSTR    = 2'h1;
  localparam logic [1:0]  BYTE_DATA     = 2'h2;

endpackage
